// ===== sspd_pkg.sv
// Package for the stepper speed-mode controller: register map, field
// layouts, profile record, state codes and timing constants.
// Assumes a 20 MHz system clock and an APB register bus.
package sspd_pkg;

  // System clock and millisecond ramp tick
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

  // Frequencies are held in units of 0.1 Hz
  localparam int unsigned FREQ_W = 20;
  localparam int unsigned GRAD_W = 15;
  localparam int unsigned TRIM_W = 22;
  localparam int unsigned ACC_W = 28;
  localparam logic [ACC_W-1:0] STEP_WRAP = 28'hBEB_C200;
  localparam logic [GRAD_W-1:0] GRAD_MIN = 15'h0001;
  localparam logic [GRAD_W-1:0] GRAD_MAX = 15'h7530;
  localparam logic [TRIM_W-1:0] TRIM_STEP = 22'h00_03E8;
  localparam logic [FREQ_W-1:0] FREQ_MAX = 20'hF_FFFF;
  localparam int unsigned SINE_SHIFT = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FREQ = 8'h0C;
  localparam logic [7:0] OFS_PIDX = 8'h10;
  localparam logic [7:0] OFS_PSTART = 8'h14;
  localparam logic [7:0] OFS_PTARGET = 8'h18;
  localparam logic [7:0] OFS_PRAMP = 8'h1C;

  // Field positions
  localparam int unsigned CTRL_SWMODE = 0;
  localparam int unsigned CTRL_SWRUN = 1;
  localparam int unsigned CTRL_IDX_LO = 2;
  localparam int unsigned CMD_INC = 0;
  localparam int unsigned CMD_DEC = 1;
  localparam int unsigned RAMP_SHAPE = 16;
  localparam int unsigned RAMP_DIR = 17;

  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [4:0] PIDX_RST = 5'h00;

  // Profile storage
  localparam int unsigned NPROF = 32;

  typedef struct packed {
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] target;
    logic [GRAD_W-1:0] grad;
    logic sine;
    logic dir;
  } sspd_prof_t;

  // Status output codes {out1, out2}
  localparam logic [1:0] CODE_RUN = 2'b01;
  localparam logic [1:0] CODE_IDLE = 2'b10;
  localparam logic [1:0] CODE_ERR = 2'b00;
  localparam logic [1:0] CODE_ZERO = 2'b11;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_REV = 2'b11,
    ST_ERR = 2'b10
  } sspd_state_t;

endpackage

// ===== sspd_core.sv
// Stepper speed-mode controller: profile store, ramp generator, step
// pulse output, status code and APB register slave.
// Assumes all inputs synchronous to i_mclk; speed fault comes from an
// external monitor and zero position from an external sensor.
//
// Behaviour
// - Run ramps from start to target frequency
// - Thirty-two stored profiles with ramp parameters
// - Inputs reach only profiles one to sixteen
// - Input mode direction comes from direction input
// - Speed setting may change at any time
// - Run input starts and stops the motor
// - Falling run edge clears speed error
// - Select inputs binary, value plus one
// - Select inputs sampled continuously while running
// - Setpoint change ramps with profile gradient
// - Two status outputs encode run/idle/error/zero
// - Stored direction used only under software command
// - Gradient is change per millisecond, both ways
// - Trapezoid or sinusoidal ramp shape per profile
// - Test run increase adds 100 Hz
// - Test run decrease removes 100 Hz
// - Present frequency readable over the bus
// - Stepping starts directly at start frequency
// - Gradient clamped between 0.1 and 3000 Hz/ms
`timescale 1ns/1ps
module sspd_core #(
  parameter int unsigned TICK_CYCLES = sspd_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Controller inputs
  input wire logic i_run,
  input wire logic [3:0] i_sel,
  input wire logic i_dir,
  input wire logic i_speed_fault,
  input wire logic i_zero_pos,
  // Motor and status outputs
  output logic o_step,
  output logic o_dir,
  output logic o_out1,
  output logic o_out2,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import sspd_pkg::*;

  sspd_prof_t prof_mem [NPROF];
  sspd_state_t state_reg;
  logic [6:0] ctrl_reg;
  logic [4:0] pidx_reg;
  logic [FREQ_W-1:0] freq_reg;
  logic [ACC_W-1:0] acc_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic [15:0] tick_reg;
  logic tick;
  logic dir_reg;
  logic run_d_reg;
  logic step_reg;
  logic [1:0] code_reg;
  logic [31:0] rdata_reg;
  logic slverr_reg;

  // Mode and active profile
  logic sw_mode;
  logic run_cmd;
  logic want_dir;
  logic [4:0] act_idx;
  sspd_prof_t act;
  logic run_fall;

  assign sw_mode = ctrl_reg[CTRL_SWMODE];
  assign run_cmd = sw_mode ? ctrl_reg[CTRL_SWRUN] : i_run;
  // Upper bit forced low in input mode keeps records 17..32 unreachable
  assign act_idx = sw_mode ? ctrl_reg[CTRL_IDX_LO +: 5] : {1'b0, i_sel};
  assign act = prof_mem[act_idx];
  assign want_dir = sw_mode ? act.dir : i_dir;
  assign run_fall = run_d_reg && !run_cmd;
  // APB decode
  logic setup;
  logic wr;
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite;
  assign o_pready = i_psel && i_penable;
  assign o_prdata = rdata_reg;
  assign o_pslverr = i_psel && i_penable && slverr_reg;
  logic cmd_inc;
  logic cmd_dec;
  logic test_run;
  assign test_run = sw_mode && (state_reg == ST_RUN);
  assign cmd_inc = wr && (i_paddr == OFS_CMD) && i_pwdata[CMD_INC];
  assign cmd_dec = wr && (i_paddr == OFS_CMD) && i_pwdata[CMD_DEC];
  // Effective setpoint with test-run trim, floored at start frequency
  logic signed [TRIM_W:0] tgt_sum;
  logic [FREQ_W-1:0] setpoint;
  logic [FREQ_W-1:0] goal;
  always_comb begin
    tgt_sum = $signed({3'b000, act.target}) + (TRIM_W + 1)'($signed(trim_reg));
    if (tgt_sum < $signed({3'b000, act.start})) begin
      setpoint = act.start;
    end else if (tgt_sum > $signed({3'b000, FREQ_MAX})) begin
      setpoint = FREQ_MAX;
    end else begin
      setpoint = tgt_sum[FREQ_W-1:0];
    end
    if (state_reg == ST_REV || !run_cmd) begin
      goal = act.start;
    end else begin
      goal = setpoint;
    end
  end
  // Ramp increment per millisecond, softened near both ramp ends
  logic [FREQ_W-1:0] gstep;
  logic [FREQ_W-1:0] band;
  logic [FREQ_W-1:0] to_goal;
  logic [FREQ_W-1:0] from_start;
  always_comb begin
    band = FREQ_W'({act.grad, 3'b000});
    to_goal = (freq_reg > goal) ? freq_reg - goal : goal - freq_reg;
    from_start = (freq_reg > act.start) ? freq_reg - act.start : '0;
    gstep = FREQ_W'(act.grad);
    if (act.sine && (to_goal < band || from_start < band)) begin
      gstep = FREQ_W'(act.grad >> 1) | FREQ_W'(1);
    end
  end
  logic [FREQ_W:0] up_sum;
  logic [FREQ_W-1:0] ramp_next;
  always_comb begin
    up_sum = {1'b0, freq_reg} + {1'b0, gstep};
    ramp_next = freq_reg;
    if (freq_reg < goal) begin
      if (up_sum[FREQ_W] || up_sum[FREQ_W-1:0] > goal) begin
        ramp_next = goal;
      end else begin
        ramp_next = up_sum[FREQ_W-1:0];
      end
    end else if (freq_reg > goal) begin
      ramp_next = (freq_reg - goal > gstep) ? freq_reg - gstep : goal;
    end
  end
  // Millisecond tick divider
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end
  assign tick = (tick_reg == 16'(TICK_CYCLES - 1));

  // Run edge tracker
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run_cmd;
    end
  end

  // Motion state, frequency and direction
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      freq_reg <= '0;
      dir_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          dir_reg <= want_dir;
          if (i_speed_fault) begin
            state_reg <= ST_ERR;
          end else if (run_cmd) begin
            state_reg <= ST_RUN;
            freq_reg <= act.start;
          end
        end
        ST_RUN: begin
          if (i_speed_fault) begin
            state_reg <= ST_ERR;
            freq_reg <= '0;
          end else if (!run_cmd && freq_reg <= act.start) begin
            state_reg <= ST_IDLE;
            freq_reg <= '0;
          end else if (run_cmd && want_dir != dir_reg) begin
            state_reg <= ST_REV;
          end else if (tick) begin
            freq_reg <= ramp_next;
          end
        end
        ST_REV: begin
          if (i_speed_fault) begin
            state_reg <= ST_ERR;
            freq_reg <= '0;
          end else if (freq_reg <= act.start) begin
            dir_reg <= want_dir;
            state_reg <= run_cmd ? ST_RUN : ST_IDLE;
            freq_reg <= run_cmd ? act.start : '0;
          end else if (tick) begin
            freq_reg <= ramp_next;
          end
        end
        ST_ERR: begin
          // A fault still present wins over the clearing edge
          if (run_fall && !i_speed_fault) begin
            state_reg <= ST_IDLE;
          end
          freq_reg <= '0;
        end
      endcase
    end
  end
  assign o_dir = dir_reg;

  // Test-run trim, dropped when the run ends
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || state_reg == ST_IDLE || state_reg == ST_ERR) begin
      trim_reg <= '0;
    end else if (test_run && cmd_inc) begin
      trim_reg <= trim_reg + TRIM_STEP;
    end else if (test_run && cmd_dec) begin
      trim_reg <= trim_reg - TRIM_STEP;
    end
  end

  // Step pulse phase accumulator
  logic [ACC_W:0] acc_sum;
  assign acc_sum = {1'b0, acc_reg} + (ACC_W + 1)'(freq_reg);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || state_reg == ST_IDLE || state_reg == ST_ERR) begin
      acc_reg <= '0;
      step_reg <= 1'b0;
    end else if (acc_sum >= {1'b0, STEP_WRAP}) begin
      acc_reg <= ACC_W'(acc_sum - {1'b0, STEP_WRAP});
      step_reg <= 1'b1;
    end else begin
      acc_reg <= acc_sum[ACC_W-1:0];
      step_reg <= 1'b0;
    end
  end
  assign o_step = step_reg;

  // Status code
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      code_reg <= CODE_IDLE;
    end else begin
      unique case (state_reg)
        ST_ERR: code_reg <= CODE_ERR;
        ST_IDLE: code_reg <= i_zero_pos ? CODE_ZERO : CODE_IDLE;
        default: code_reg <= CODE_RUN;
      endcase
    end
  end
  assign o_out1 = code_reg[1];
  assign o_out2 = code_reg[0];

  // Control and profile index registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_reg <= CTRL_RST;
      pidx_reg <= PIDX_RST;
    end else if (wr && i_paddr == OFS_CTRL) begin
      ctrl_reg <= i_pwdata[6:0];
    end else if (wr && i_paddr == OFS_PIDX) begin
      pidx_reg <= i_pwdata[4:0];
    end
  end

  // Profile store, written through the index register
  logic [GRAD_W-1:0] grad_clamped;
  always_comb begin
    grad_clamped = i_pwdata[GRAD_W-1:0];
    if (i_pwdata[15:0] > 16'(GRAD_MAX)) begin
      grad_clamped = GRAD_MAX;
    end else if (i_pwdata[GRAD_W-1:0] < GRAD_MIN) begin
      grad_clamped = GRAD_MIN;
    end
  end

  // No reset on the store: contents are loaded by software before use
  always_ff @(posedge i_mclk) begin
    if (wr && i_paddr == OFS_PSTART) begin
      prof_mem[pidx_reg].start <= i_pwdata[FREQ_W-1:0];
    end
    if (wr && i_paddr == OFS_PTARGET) begin
      prof_mem[pidx_reg].target <= i_pwdata[FREQ_W-1:0];
    end
    if (wr && i_paddr == OFS_PRAMP) begin
      prof_mem[pidx_reg].grad <= grad_clamped;
      prof_mem[pidx_reg].sine <= i_pwdata[RAMP_SHAPE];
      prof_mem[pidx_reg].dir <= i_pwdata[RAMP_DIR];
    end
  end

  // Read data captured in the setup cycle
  sspd_prof_t sel;
  assign sel = prof_mem[pidx_reg];
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= 1'b0;
      rdata_reg <= '0;
      unique case (i_paddr)
        OFS_CTRL: rdata_reg <= {25'h000_0000, ctrl_reg};
        OFS_CMD: rdata_reg <= '0;
        OFS_STATUS: rdata_reg <= {26'h000_0000, dir_reg,
          state_reg == ST_ERR, code_reg, state_reg};
        OFS_FREQ: rdata_reg <= {12'h000, freq_reg};
        OFS_PIDX: rdata_reg <= {27'h000_0000, pidx_reg};
        OFS_PSTART: rdata_reg <= {12'h000, sel.start};
        OFS_PTARGET: rdata_reg <= {12'h000, sel.target};
        OFS_PRAMP: rdata_reg <= {14'h0000, sel.dir, sel.sine, 1'b0,
          sel.grad};
        default: slverr_reg <= 1'b1;
      endcase
    end
  end

  // Checks
  a_err_code: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_ERR |=> {o_out1, o_out2} == CODE_ERR)
    else $error("error state without error code");
  a_err_no_step: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_ERR ##1 state_reg == ST_ERR |-> !o_step)
    else $error("step while in error");
  a_err_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_ERR && run_fall && !i_speed_fault
    |=> state_reg == ST_IDLE)
    else $error("falling run edge did not clear error");
  a_input_sel: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !sw_mode |-> act_idx == {1'b0, i_sel})
    else $error("input mode selected a high profile");
  a_dir_follow: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_RUN && run_cmd && !i_speed_fault && !sw_mode
    && i_dir != dir_reg |=> state_reg == ST_REV)
    else $error("direction input change not followed");
  a_start_jump: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_IDLE && run_cmd && !i_speed_fault
    |=> state_reg == ST_RUN && freq_reg == $past(act.start))
    else $error("run did not begin at start frequency");
  a_ramp_rate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    state_reg == ST_RUN && !tick && !i_speed_fault && run_cmd
    |=> $stable(freq_reg))
    else $error("frequency moved between ramp ticks");
  a_trim_inc: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    test_run && cmd_inc && !i_speed_fault
    |=> trim_reg == $past(trim_reg) + TRIM_STEP)
    else $error("increase did not add 100 Hz");
  a_trim_dec: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    test_run && cmd_dec && !cmd_inc && !i_speed_fault
    |=> trim_reg == $past(trim_reg) - TRIM_STEP)
    else $error("decrease did not remove 100 Hz");
  a_freq_read: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    setup && i_paddr == OFS_FREQ
    |=> o_prdata == {12'h000, $past(freq_reg)})
    else $error("frequency read mismatch");

endmodule

// ===== sspd_ctl_model.sv
// Model of the upstream controller: drives the run, speed select and
// direction lines as levels, each changed just after a clock edge.
// Assumes the bench asks for levels through the request inputs.
`timescale 1ns/1ps
module sspd_ctl_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Requests from the bench
  input wire logic i_cmd_run,
  input wire logic [3:0] i_cmd_sel,
  input wire logic i_cmd_dir,
  // Lines to the device
  output logic o_run,
  output logic [3:0] o_sel,
  output logic o_dir
);
  // Lines held low in reset so no run is seen before release
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_run <= 1'b0;
      o_sel <= 4'h0;
      o_dir <= 1'b0;
    end else begin
      o_run <= i_cmd_run;
      o_sel <= i_cmd_sel;
      o_dir <= i_cmd_dir;
    end
  end
endmodule

// ===== stepper_speed_mode_control_test.sv
// Self-checking bench for the speed-mode controller core.
// Assumes the core's zero-wait APB slave and a shortened ramp tick.
`timescale 1ns/1ps
module stepper_speed_mode_control_test;
  import sspd_pkg::*;
  localparam logic [19:0] F0 = 20'h1_86A0;
  localparam logic [14:0] G0 = 15'h2710;
  logic i_mclk, i_sys_rst, run, dir, fault, zero, o_step, o_dir;
  logic cmd_run, cmd_dir, o_out1, o_out2, psel, penable, pwrite;
  logic o_pready, o_pslverr;
  logic [3:0] sel, cmd_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, o_prdata;
  logic [32:0] expq[$];
  logic [19:0] tgt [16];
  int mismatches, n_checks, n_steps, cyc, seed;

  sspd_core #(.TICK_CYCLES(20)) sspd_core_inst (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_run(run), .i_sel(sel), .i_dir(dir),
    .i_speed_fault(fault), .i_zero_pos(zero), .o_step(o_step),
    .o_dir(o_dir), .o_out1(o_out1), .o_out2(o_out2), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));
  sspd_ctl_model sspd_ctl_model_inst (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_cmd_run(cmd_run), .i_cmd_sel(cmd_sel),
    .i_cmd_dir(cmd_dir), .o_run(run), .o_sel(sel), .o_dir(dir));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic end_sim();
    if (expq.size() != 0) begin
      mismatches++;
    end
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // An idle cycle between transfers keeps each signal to one write a step
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (o_pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    expq.push_back({err, e});
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic code_is(input logic [1:0] c);
    check("status code", 33'({o_out1, o_out2}), 33'(c));
  endtask

  task automatic prof(input logic [4:0] i, input logic [19:0] f,
                      input logic [19:0] t, input logic [31:0] r);
    wr(OFS_PIDX, 32'(i));
    wr(OFS_PSTART, 32'(f));
    wr(OFS_PTARGET, 32'(t));
    wr(OFS_PRAMP, r);
    rd(OFS_PTARGET, 32'(t), 1'b0);
  endtask

  // Read results are matched against the oldest note in the queue
  always @(posedge i_mclk) begin
    if (psel && penable && o_pready === 1'b1 && !pwrite) begin
      if (expq.size() > 0) begin
        check("apb read", {o_pslverr, o_prdata}, expq.pop_front());
      end
    end
  end

  always @(posedge i_mclk) begin
    if (o_step === 1'b1) begin
      n_steps <= n_steps + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    int s;
    int k;
    int st;
    {psel, penable, pwrite, cmd_run, cmd_dir, fault, zero} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cmd_sel = 4'h0;
    n_steps = 0;
    cyc = 0;
    seed = 32'h0000_73c4;
    i_sys_rst = 1'b1;
    wait_cyc(4);
    i_sys_rst <= 1'b0;
    code_is(CODE_IDLE);
    rd(OFS_CTRL, 32'h0000_0000, 1'b0);
    rd(OFS_STATUS, 32'h0000_0008, 1'b0);
    rd(OFS_FREQ, 32'h0000_0000, 1'b0);
    rd(8'h20, 32'h0000_0000, 1'b1);
    wr(OFS_PIDX, 32'h0000_001E);
    wr(OFS_PRAMP, 32'h0000_0000);
    rd(OFS_PRAMP, 32'h0000_0001, 1'b0);
    wr(OFS_PRAMP, 32'h0000_7FFF);
    rd(OFS_PRAMP, 32'(GRAD_MAX), 1'b0);
    // Stored direction set on all input profiles so the line must win
    for (int i = 0; i < 16; i++) begin
      k = (i == 0) ? 0 : 1 + ($random(seed) & 7);
      tgt[i] = F0 + 20'(k) * 20'(G0);
      prof(5'(i), F0, tgt[i], {14'h0000, 1'b1, i[0], 1'b0, G0});
    end
    prof(5'h1F, F0, 20'h3_0D40, {14'h0000, 2'b10, 1'b0, GRAD_MAX});
    cmd_run <= 1'b1;
    wait_cyc(4);
    code_is(CODE_RUN);
    wait_cyc(100);
    rd(OFS_FREQ, 32'(F0), 1'b0);
    check("dir", 33'(o_dir), 33'(1'b0));
    st = n_steps;
    // Odd stride visits every nonzero select value, going up and down
    for (int j = 1; j < 16; j++) begin
      s = (j * 7) & 15;
      cmd_sel <= 4'(s);
      wait_cyc(700);
      rd(OFS_FREQ, 32'(tgt[s]), 1'b0);
    end
    check("steps", 33'(n_steps != st), 33'(1'b1));
    cmd_dir <= 1'b1;
    wait_cyc(1500);
    check("dir", 33'(o_dir), 33'(1'b1));
    rd(OFS_FREQ, 32'(tgt[s]), 1'b0);
    fault <= 1'b1;
    wait_cyc(3);
    code_is(CODE_ERR);
    rd(OFS_FREQ, 32'h0000_0000, 1'b0);
    st = n_steps;
    wait_cyc(3000);
    check("steps", 33'(n_steps), 33'(st));
    fault <= 1'b0;
    wait_cyc(3);
    code_is(CODE_ERR);
    cmd_run <= 1'b0;
    wait_cyc(4);
    code_is(CODE_IDLE);
    zero <= 1'b1;
    wait_cyc(3);
    code_is(CODE_ZERO);
    zero <= 1'b0;
    cmd_dir <= 1'b0;
    cmd_sel <= 4'hF;
    wr(OFS_CTRL, 32'h0000_007F);
    wait_cyc(4);
    code_is(CODE_RUN);
    wait_cyc(300);
    rd(OFS_FREQ, 32'h0003_0D40, 1'b0);
    // 20 kHz gives exactly one step every 1000 cycles
    st = n_steps;
    wait_cyc(2000);
    check("step rate", 33'(n_steps - st), 33'(2));
    check("dir", 33'(o_dir), 33'(1'b1));
    wr(OFS_CMD, 32'h0000_0001);
    wait_cyc(200);
    rd(OFS_FREQ, 32'h0003_0D40 + 32'(TRIM_STEP), 1'b0);
    wr(OFS_CMD, 32'h0000_0002);
    wr(OFS_CMD, 32'h0000_0002);
    wait_cyc(200);
    rd(OFS_FREQ, 32'h0003_0D40 - 32'(TRIM_STEP), 1'b0);
    wr(OFS_CTRL, 32'h0000_0000);
    wait_cyc(600);
    code_is(CODE_IDLE);
    rd(OFS_FREQ, 32'h0000_0000, 1'b0);
    wait_cyc(4);
    end_sim();
  end
endmodule
